/* bench/bsr_host.sv */
`timescale 1ns/1ps
module bsr_host
   import bsr_pkg::*;
(
   input  wire logic clk,
   output bsr_bus_t  bus
);
   initial bus = '0;
   task automatic io(input logic rd, input logic [7:0] d);
      @(negedge clk);
      bus = '{addr:16'h0040, data:d, io_wr:!rd, io_rd:rd, default:'0};
      @(negedge clk);
      bus = '0;
      bus.data = ~d;
   endtask
   task automatic mem(input logic [15:0] a);
      @(negedge clk);
      bus = '{addr:a, mem_rd:1'b1, cycle_start:1'b1, default:'0};
      #1;
   endtask
   task automatic nxt();
      @(negedge clk);
      bus.cycle_start = 1'b0;
      #1;
   endtask
endmodule // bsr_host

/* bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   import bsr_pkg::*;
   typedef struct {logic [2:0] s; logic [7:0] d; logic e;} row_t;
   logic           clk, rst_n, sw, swd, pf, wo, mm, dq, dn;
   logic [2:0]     bs;
   bsr_bank_mode_t md;
   logic [3:0]     dr, cr;
   bsr_bus_t       bus;
   logic           ce, lamp, rom, cms, ph, rdy, ii, nmi;
   logic [7:0]     vl;
   int             n_fail, checks_done;
   row_t           rows [5] = '{'{3'h3, 8'h08, 1'b1}, '{3'h3, 8'h01, 1'b0},
      '{3'h0, 8'h01, 1'b1}, '{3'h3, 8'h00, 1'b0}, '{3'h3, 8'hFF, 1'b1}};
   bsr_host h (.clk(clk), .bus(bus));
   bsr_decode DUT (.clk(clk), .rst_n(rst_n), .bus(bus), .bank_strap(bs),
      .bank_mode_strap(md), .rom_sw_mode_strap(sw), .rom_sw_disable(swd),
      .partial_firmware_strap(pf), .wait_off_strap(wo), .mmap_strap(mm),
      .data_request(dq), .command_done_request(dn), .drq_route(dr),
      .done_route(cr), .card_enabled(ce), .bank_lamp(lamp), .rom_select(rom),
      .ctrl_mem_select(cms), .phantom(ph), .ready(rdy), .irq_int(ii),
      .irq_nmi(nmi), .vectored_interrupt_lines(vl));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      checks_done++;
      if (s !== e) begin
         n_fail++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic rst(input bsr_bank_mode_t m);
      md = m;
      rst_n = 1'b0;
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
   endtask
   task automatic print_verdict();
      $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      {sw, swd, pf, wo, mm, dq, dn} = '0;
      bs = 3'h3;
      dr = 4'hF;
      cr = 4'hF;
      n_fail = 0;
      checks_done = 0;
      rst(BSR_EN_ON_RESET);
      chk(ce, 1'b1);
      h.mem(16'hF000);
      chk({rom, ph, rdy}, 3'b110);
      h.nxt();
      chk(rdy, 1'b0);
      h.nxt();
      chk(rdy, 1'b1);
      wo = 1'b1;
      h.mem(16'hF000);
      chk(rdy, 1'b1);
      mm = 1'b1;
      for (int a = 16'hFFF7; a <= 16'hFFFE; a++) begin
         h.mem(16'(a));
         chk(cms, 16'(a >= 16'hFFF8 && a <= 16'hFFFD));
      end
      for (int i = 0; i < 5; i++) begin
         bs = rows[i].s;
         h.io(1'b0, rows[i].d);
         chk({ce, lamp}, {2{rows[i].e}});
      end
      h.mem(16'hF000);
      chk(rom, 1'b0);
      pf = 1'b1;
      h.mem(16'hF600);
      chk(rom, 1'b1);
      h.mem(16'hF5FF);
      chk(rom, 1'b0);
      h.io(1'b1, 8'h00);
      chk(ce, 1'b1);
      rst(BSR_EN_ALWAYS);
      h.io(1'b0, 8'h00);
      chk(ce, 1'b1);
      rst(BSR_EN_AFTER_SELECT);
      chk(ce, 1'b0);
      h.io(1'b0, 8'h08);
      chk(ce, 1'b1);
      sw = 1'b1;
      h.io(1'b0, 8'h08);
      h.mem(16'hF000);
      chk(rom, 1'b1);
      swd = 1'b1;
      h.mem(16'hF000);
      chk(rom, 1'b0);
      swd = 1'b0;
      wo = 1'b0;
      h.mem(16'hF000);
      chk({rom, rdy}, 2'b10);
      h.nxt();
      h.nxt();
      h.mem(16'hFFF8);
      chk({cms, rdy}, 2'b10);
      h.nxt();
      chk(rdy, 1'b0);
      h.nxt();
      chk(rdy, 1'b1);
      mm = 1'b0;
      pf = 1'b0;
      h.mem(16'hFFF8);
      chk({cms, rdy}, 2'b01);
      h.nxt();
      for (int r = 0; r < 10; r++) begin
         dr = 4'(r);
         cr = 4'(9 - r);
         {dq, dn} = 2'b11;
         repeat (3) @(negedge clk);
         chk({nmi, ii, vl}, 16'((1 << r) | (1 << (9 - r))));
         {dq, dn} = 2'b00;
         repeat (2) @(negedge clk);
         chk({nmi, ii, vl}, 16'h0000);
      end
      print_verdict();
   end
endmodule // tb_top

/* verilog/bsr_decode.sv */
`timescale 1ns/1ps
module bsr_decode
   import bsr_pkg::*;
#(
   parameter int BANKS = BSR_NUM_BANKS
) (
   input  wire logic           clk,
   input  wire logic           rst_n,
   input  wire bsr_bus_t       bus,
   input  wire logic [2:0]     bank_strap,
   input  wire bsr_bank_mode_t bank_mode_strap,
   input  wire logic           rom_sw_mode_strap,
   input  wire logic           rom_sw_disable,
   input  wire logic           partial_firmware_strap,
   input  wire logic           wait_off_strap,
   input  wire logic           mmap_strap,
   input  wire logic           data_request,
   input  wire logic           command_done_request,
   input  wire logic [3:0]     drq_route,
   input  wire logic [3:0]     done_route,
   output logic                card_enabled,
   output logic                bank_lamp,
   output logic                rom_select,
   output logic                ctrl_mem_select,
   output logic                phantom,
   output logic                ready,
   output logic                irq_int,
   output logic                irq_nmi,
   output logic [7:0]          vectored_interrupt_lines
);

   initial begin
      if (BANKS != BSR_NUM_BANKS) begin
         $error("bsr_decode: BANKS must be eight");
      end
   end

   bsr_state_t st_ff;
   bsr_state_t nxt_st;
   logic       bank_wr;
   logic       own_bit;
   logic       rom_hit;
   logic       part_hit;
   logic       mm_hit;
   logic       slow_hit;

   function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   function automatic logic route_hit(input logic [3:0] route, input logic [3:0] dest, input logic req);
      route_hit = req && (route == dest);
   endfunction

   assign bank_wr  = bus.io_wr && (bus.addr[7:0] == BSR_BANK_PORT);
   assign own_bit  = bus.data[bank_strap];
   assign rom_hit  = (bus.mem_rd || bus.mem_wr) && in_range(bus.addr, BSR_ROM_BASE, BSR_ROM_LAST);
   assign part_hit = (bus.mem_rd || bus.mem_wr) && in_range(bus.addr, BSR_PART_BASE, BSR_PART_LAST);
   assign mm_hit   = (bus.mem_rd || bus.mem_wr) && in_range(bus.addr, BSR_MMAP_BASE, BSR_MMAP_LAST);

   always_comb begin
      nxt_st = st_ff;
      if (bank_wr) begin
         case (bank_mode_strap)
            BSR_EN_ON_RESET:     nxt_st.card_en = own_bit;
            BSR_EN_AFTER_SELECT: nxt_st.card_en = own_bit;
            BSR_EN_ALWAYS:       nxt_st.card_en = 1'b1;
            default:             nxt_st.card_en = own_bit;
         endcase
      end
      if (bank_mode_strap == BSR_EN_ALWAYS) begin
         nxt_st.card_en = 1'b1;
      end
      if (!rom_sw_mode_strap && bank_wr) begin
         nxt_st.rom_en = 1'b0;
      end
      if (rom_sw_mode_strap) begin
         nxt_st.rom_en = !rom_sw_disable;
      end
      nxt_st.wait_active = 1'b0;
      if (bus.cycle_start && slow_hit && !wait_off_strap) begin
         nxt_st.wait_cnt    = BSR_WAIT_CNT_INIT;
         nxt_st.wait_active = 1'b1;
      end else if (st_ff.wait_cnt != 2'h0) begin
         nxt_st.wait_cnt = st_ff.wait_cnt - 2'h1;
      end
      nxt_st.drq_sync  = {st_ff.drq_sync[0], data_request};
      nxt_st.done_sync = {st_ff.done_sync[0], command_done_request};
      if (!rst_n) begin
         nxt_st.card_en     = (bank_mode_strap != BSR_EN_AFTER_SELECT);
         nxt_st.rom_en      = 1'b1;
         nxt_st.wait_cnt    = 2'h0;
         nxt_st.wait_active = 1'b0;
         nxt_st.drq_sync    = 2'h0;
         nxt_st.done_sync   = 2'h0;
      end
   end

   always_ff @(posedge clk) begin
      st_ff <= nxt_st;
   end

   assign rom_select      = st_ff.card_en && rom_hit && (st_ff.rom_en || (partial_firmware_strap && part_hit));
   assign ctrl_mem_select = st_ff.card_en && mmap_strap && mm_hit;
   assign slow_hit        = (rom_select || ctrl_mem_select);
   assign phantom         = rom_select;
   assign ready           = !(bus.cycle_start && slow_hit && !wait_off_strap) && !st_ff.wait_active;
   assign card_enabled    = st_ff.card_en;
   assign bank_lamp       = st_ff.card_en;

   assign irq_int = route_hit(drq_route, BSR_DEST_INT, st_ff.drq_sync[1])
                  || route_hit(done_route, BSR_DEST_INT, st_ff.done_sync[1]);
   assign irq_nmi = route_hit(drq_route, BSR_DEST_NMI, st_ff.drq_sync[1])
                  || route_hit(done_route, BSR_DEST_NMI, st_ff.done_sync[1]);
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_vi
         assign vectored_interrupt_lines[g] = route_hit(drq_route, 4'(g), st_ff.drq_sync[1])
                                            || route_hit(done_route, 4'(g), st_ff.done_sync[1]);
      end
   endgenerate

   property p_foreign_bank;
      @(posedge clk) disable iff (!rst_n)
         (bank_wr && !own_bit && bank_mode_strap != BSR_EN_ALWAYS) |=> !card_enabled;
   endproperty
   a_foreign_bank: assert property (p_foreign_bank) else $error("card still enabled");

   property p_own_bank;
      @(posedge clk) disable iff (!rst_n) (bank_wr && own_bit) |=> card_enabled;
   endproperty
   a_own_bank: assert property (p_own_bank) else $error("card not enabled");

   property p_always;
      @(posedge clk) disable iff (!rst_n) (bank_mode_strap == BSR_EN_ALWAYS) |=> card_enabled;
   endproperty
   a_always: assert property (p_always) else $error("always mode disabled");

   property p_reset_state;
      @(posedge clk) $rose(rst_n) |-> (rom_sw_mode_strap || st_ff.rom_en)
         && (card_enabled == (bank_mode_strap != BSR_EN_AFTER_SELECT));
   endproperty
   a_reset_state: assert property (p_reset_state) else $error("bad reset state");

   property p_hw_rom_off;
      @(posedge clk) disable iff (!rst_n) (bank_wr && !rom_sw_mode_strap) |=> !st_ff.rom_en;
   endproperty
   a_hw_rom_off: assert property (p_hw_rom_off) else $error("rom still enabled");

   property p_sw_rom;
      @(posedge clk) disable iff (!rst_n) rom_sw_mode_strap |=> (st_ff.rom_en == !$past(rom_sw_disable));
   endproperty
   a_sw_rom: assert property (p_sw_rom) else $error("sw rom bit ignored");

   property p_lamp;
      @(posedge clk) disable iff (!rst_n) bank_lamp == card_enabled;
   endproperty
   a_lamp: assert property (p_lamp) else $error("lamp mismatch");

   property p_wait_one;
      @(posedge clk) disable iff (!rst_n)
         (bus.cycle_start && slow_hit && !wait_off_strap) |-> !ready ##1 !ready ##1 ready;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("wait length wrong");

   property p_partial;
      @(posedge clk) disable iff (!rst_n)
         (card_enabled && partial_firmware_strap && part_hit) |-> rom_select && phantom;
   endproperty
   a_partial: assert property (p_partial) else $error("partial window lost");

   property p_mmap;
      @(posedge clk) disable iff (!rst_n) ctrl_mem_select |-> (mmap_strap && bus.addr >= BSR_MMAP_BASE);
   endproperty
   a_mmap: assert property (p_mmap) else $error("bad mmap select");

   property p_drq_route;
      @(posedge clk) disable iff (!rst_n)
         (data_request && drq_route == BSR_DEST_NMI) [*3] |-> irq_nmi;
   endproperty
   a_drq_route: assert property (p_drq_route) else $error("drq not routed");

   property p_hold_card;
      @(posedge clk) disable iff (!rst_n)
         !bank_wr
         |=> $stable(card_enabled);
   endproperty
   a_hold_card: assert property (p_hold_card) else $error("card state moved without bank write");

   property p_io_rd_ignored;
      @(posedge clk) disable iff (!rst_n)
         (bus.io_rd && !bus.io_wr && !rom_sw_mode_strap)
         |=> $stable(card_enabled) && $stable(st_ff.rom_en);
   endproperty
   a_io_rd_ignored: assert property (p_io_rd_ignored) else $error("bank port read changed state");

   property p_hw_rom_hold;
      @(posedge clk) disable iff (!rst_n)
         (!rom_sw_mode_strap && !bank_wr)
         |=> $stable(st_ff.rom_en);
   endproperty
   a_hw_rom_hold: assert property (p_hw_rom_hold) else $error("rom state moved without bank write");

   property p_reset_rom;
      @(posedge clk)
         !rst_n
         |=> st_ff.rom_en;
   endproperty
   a_reset_rom: assert property (p_reset_rom) else $error("rom not enabled by reset");

   property p_reset_card;
      @(posedge clk)
         !rst_n
         |=> (card_enabled == (bank_mode_strap != BSR_EN_AFTER_SELECT));
   endproperty
   a_reset_card: assert property (p_reset_card) else $error("wrong card state after reset");

   property p_rom_needs_card;
      @(posedge clk) disable iff (!rst_n)
         !card_enabled
         |-> !rom_select && !ctrl_mem_select;
   endproperty
   a_rom_needs_card: assert property (p_rom_needs_card) else $error("disabled card still selects");

   property p_phantom;
      @(posedge clk) disable iff (!rst_n)
         (card_enabled && st_ff.rom_en && rom_hit)
         |-> phantom;
   endproperty
   a_phantom: assert property (p_phantom) else $error("phantom missing on firmware access");

   property p_wait_off;
      @(posedge clk) disable iff (!rst_n)
         wait_off_strap
         |-> ready;
   endproperty
   a_wait_off: assert property (p_wait_off) else $error("wait inserted with strap fitted");

   property p_wait_span;
      @(posedge clk) disable iff (!rst_n)
         (bus.cycle_start && slow_hit && !wait_off_strap)
         |=> st_ff.wait_active;
   endproperty
   a_wait_span: assert property (p_wait_span) else $error("wait state not registered");

   property p_mmap_off;
      @(posedge clk) disable iff (!rst_n)
         !mmap_strap
         |-> !ctrl_mem_select;
   endproperty
   a_mmap_off: assert property (p_mmap_off) else $error("controller mapped without strap");

   property p_mmap_range;
      @(posedge clk) disable iff (!rst_n)
         ctrl_mem_select
         |-> (bus.addr <= BSR_MMAP_LAST) && (bus.mem_rd || bus.mem_wr);
   endproperty
   a_mmap_range: assert property (p_mmap_range) else $error("controller select out of range");

   property p_rom_range;
      @(posedge clk) disable iff (!rst_n)
         rom_select
         |-> (bus.addr >= BSR_ROM_BASE) && (bus.addr <= BSR_ROM_LAST);
   endproperty
   a_rom_range: assert property (p_rom_range) else $error("rom select out of range");

   property p_partial_only;
      @(posedge clk) disable iff (!rst_n)
         (rom_select && !st_ff.rom_en)
         |-> partial_firmware_strap && (bus.addr >= BSR_PART_BASE);
   endproperty
   a_partial_only: assert property (p_partial_only) else $error("disabled rom still selected");

   property p_done_route;
      @(posedge clk) disable iff (!rst_n)
         (command_done_request && done_route == BSR_DEST_INT) [*3]
         |-> irq_int;
   endproperty
   a_done_route: assert property (p_done_route) else $error("command done not routed");

   property p_drq_vi;
      @(posedge clk) disable iff (!rst_n)
         (data_request && drq_route == 4'h2) [*3]
         |-> vectored_interrupt_lines[2];
   endproperty
   a_drq_vi: assert property (p_drq_vi) else $error("data request not on vectored line");

   property p_irq_quiet;
      @(posedge clk) disable iff (!rst_n)
         (!data_request && !command_done_request) [*3]
         |-> !irq_int && !irq_nmi && (vectored_interrupt_lines == 8'h00);
   endproperty
   a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt without request");

   property p_irq_unrouted;
      @(posedge clk) disable iff (!rst_n)
         (drq_route > 4'h9 && done_route > 4'h9)
         |-> !irq_int && !irq_nmi && (vectored_interrupt_lines == 8'h00);
   endproperty
   a_irq_unrouted: assert property (p_irq_unrouted) else $error("unrouted request drives a line");

   c_mmap_wait: cover property (@(posedge clk) disable iff (!rst_n) ctrl_mem_select && !ready);
   c_bank_sel: cover property (@(posedge clk) disable iff (!rst_n) bank_wr && own_bit);
   c_bank_off: cover property (@(posedge clk) disable iff (!rst_n) bank_wr && !own_bit);
   c_wait:     cover property (@(posedge clk) disable iff (!rst_n) !ready);
   c_partial:  cover property (@(posedge clk) disable iff (!rst_n) rom_select && !st_ff.rom_en);

endmodule // bsr_decode

/* verilog/bsr_pkg.sv */
package bsr_pkg;
   localparam logic [7:0]  BSR_BANK_PORT      = 8'h40;
   localparam int          BSR_NUM_BANKS      = 8;
   localparam logic [15:0] BSR_ROM_BASE       = 16'hF000;
   localparam logic [15:0] BSR_ROM_LAST       = 16'hF7FF;
   localparam logic [15:0] BSR_PART_BASE      = 16'hF600;
   localparam logic [15:0] BSR_PART_LAST      = 16'hF7FF;
   localparam logic [15:0] BSR_MMAP_BASE      = 16'hFFF8;
   localparam logic [15:0] BSR_MMAP_LAST      = 16'hFFFD;
   localparam int          BSR_CTRL2_ROM_BIT  = 1;
   localparam int          BSR_WAIT_CYCLES    = 1;
   localparam logic [1:0]  BSR_WAIT_CNT_INIT  = 2'h1;
   localparam int          BSR_NUM_IRQ_DEST   = 10;
   localparam logic [3:0]  BSR_DEST_INT       = 4'h8;
   localparam logic [3:0]  BSR_DEST_NMI       = 4'h9;

   typedef enum logic [1:0] {
      BSR_EN_ON_RESET,
      BSR_EN_AFTER_SELECT,
      BSR_EN_ALWAYS,
      BSR_EN_RSVD
   } bsr_bank_mode_t;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  data;
      logic        io_wr;
      logic        io_rd;
      logic        mem_rd;
      logic        mem_wr;
      logic        cycle_start;
   } bsr_bus_t;

   typedef struct packed {
      logic        card_en;
      logic        rom_en;
      logic [1:0]  wait_cnt;
      logic        wait_active;
      logic [1:0]  drq_sync;
      logic [1:0]  done_sync;
   } bsr_state_t;
endpackage
